/* File: include/swt_pkg.sv */
/*
 * Constants for the sleep wake-up timer: register offsets, field positions,
 * source codes, prescaler divisors and timing figures.
 * Assumes a 20 MHz system clock and 32.768 kHz tick pulses from the oscillators.
 */
package swt_pkg;
    localparam int          CLK_HZ            = 20_000_000;
    localparam int          ADDR_W            = 11;
    localparam logic [10:0] OFS_PRESCALER_CFG = 11'h316;
    localparam logic [10:0] OFS_SLEEP_CLK_CFG = 11'h317;
    localparam logic [10:0] OFS_RELOAD_LOW    = 11'h318;
    localparam logic [10:0] OFS_RELOAD_HIGH   = 11'h319;
    localparam logic [10:0] OFS_TIMER_CTRL    = 11'h31A;
    localparam logic [10:0] OFS_OSC_STATE     = 11'h31B;
    localparam logic [10:0] OFS_LINE_ONE_EN   = 11'h31C;
    localparam logic [10:0] OFS_LINE_TWO_EN   = 11'h31D;
    localparam logic [10:0] OFS_COUNT_LOW     = 11'h31E;
    localparam logic [10:0] OFS_COUNT_HIGH    = 11'h31F;
    // Field positions.
    localparam int          PRESC_LSB         = 0;
    localparam int          PRESC_W           = 3;
    localparam int          SRC_LSB           = 3;
    localparam int          SRC_W             = 4;
    localparam int          ARM_BIT           = 7;
    localparam int          FLAG_RESET_BIT    = 0;
    localparam int          CAL_TRIG_BIT      = 1;
    localparam int          CAL_DONE_BIT      = 0;
    localparam int          FLAG_BIT          = 1;
    localparam int          RUN_BIT           = 2;
    localparam int          WAKE_IRQ_BIT      = 0;
    // Clock source codes of the sleep clock select field.
    localparam logic [3:0]  SRC_RC            = 4'h1;
    localparam logic [3:0]  SRC_XTAL          = 4'h2;
    localparam logic [7:0]  CFG_RESET         = 8'h00;
    localparam logic [15:0] COUNT_ONE         = 16'h0001;
    localparam logic [15:0] COUNT_ZERO        = 16'h0000;
    // Prescaler divisors minus one, per code.
    localparam logic [15:0] DIVM1_1           = 16'h0000;
    localparam logic [15:0] DIVM1_4           = 16'h0003;
    localparam logic [15:0] DIVM1_8           = 16'h0007;
    localparam logic [15:0] DIVM1_16          = 16'h000F;
    localparam logic [15:0] DIVM1_128         = 16'h007F;
    localparam logic [15:0] DIVM1_1024        = 16'h03FF;
    localparam logic [15:0] DIVM1_8192        = 16'h1FFF;
    localparam logic [15:0] DIVM1_65536       = 16'hFFFF;
    // Typical RC calibration time.
    localparam int          CAL_TIME_US       = 1000;
    localparam int          CAL_CYCLES        = CAL_TIME_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        SWT_CAL_IDLE = 2'b01,
        SWT_CAL_RUN  = 2'b10
    } swt_cal_e;
endpackage

/* File: design/swt_timer.sv */
/*
 * Sleep wake-up timer: source select, 3-bit prescaler, 16-bit reloading
 * down counter, sticky timeout flag, two interrupt lines, wake request and
 * RC oscillator calibration sequencer, all behind a byte register port.
 * Assumes the oscillator ticks arrive as one-cycle pulses synchronous to clk_sys
 * and that register writes are single-cycle strobes.
 */
`timescale 1ns/10ps
`default_nettype none
module swt_timer #(
    parameter int CAL_CYCLES = swt_pkg::CAL_CYCLES
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       rc_tick,
    input  wire logic                       xtal_tick,
    input  wire logic                       reg_wr,
    input  wire logic [swt_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    output logic      [7:0]                 reg_rdata,
    output logic                            irq_line_one,
    output logic                            irq_line_two,
    output logic                            wake_req,
    output logic                            rc_cal_active
);
    import swt_pkg::*;

    logic [7:0]  presc_cfg_q;
    logic [7:0]  sleep_cfg_q;
    logic [15:0] reload_q;
    logic [7:0]  en_one_q;
    logic [7:0]  en_two_q;
    logic        flag_reset_q;
    logic        cal_trig_q;
    logic        flag_q;
    logic        done_q;
    logic [15:0] count_q;
    logic [15:0] pre_q;
    logic [31:0] cal_cnt_q;
    swt_cal_e    cal_state_q;
    logic [3:0]  src;
    logic        clk_en;
    logic        tick_sel;
    logic        step;
    logic        hit;
    logic        flag_clr;
    logic        cal_start;
    logic [15:0] div_m1;
    logic        reload_wr;
    logic [15:0] reload_d;

    function automatic logic [15:0] presc_div_m1(input logic [PRESC_W-1:0] code);
        case (code)
            3'd0:    presc_div_m1 = DIVM1_1;
            3'd1:    presc_div_m1 = DIVM1_4;
            3'd2:    presc_div_m1 = DIVM1_8;
            3'd3:    presc_div_m1 = DIVM1_16;
            3'd4:    presc_div_m1 = DIVM1_128;
            3'd5:    presc_div_m1 = DIVM1_1024;
            3'd6:    presc_div_m1 = DIVM1_8192;
            default: presc_div_m1 = DIVM1_65536;
        endcase
    endfunction

    function automatic logic wr_to(input logic [ADDR_W-1:0] ofs);
        wr_to = reg_wr && (reg_addr == ofs);
    endfunction

    assign src    = sleep_cfg_q[SRC_LSB +: SRC_W];
    assign clk_en   = (src == SRC_RC) || (src == SRC_XTAL);
    assign tick_sel = (src == SRC_RC) ? rc_tick : ((src == SRC_XTAL) ? xtal_tick : 1'b0);
    assign div_m1 = presc_div_m1(presc_cfg_q[PRESC_LSB +: PRESC_W]);
    assign step   = clk_en && tick_sel && (pre_q >= div_m1);
    assign hit    = step && !reload_wr && (count_q == COUNT_ONE);
    assign reload_wr = wr_to(OFS_RELOAD_LOW) || wr_to(OFS_RELOAD_HIGH) || wr_to(OFS_PRESCALER_CFG);
    assign reload_d  = wr_to(OFS_RELOAD_LOW) ? {reload_q[15:8], reg_wdata} :
                       (wr_to(OFS_RELOAD_HIGH) ? {reg_wdata, reload_q[7:0]} : reload_q);
    assign flag_clr  = wr_to(OFS_TIMER_CTRL) && flag_reset_q && !reg_wdata[FLAG_RESET_BIT];
    assign cal_start = wr_to(OFS_TIMER_CTRL) && !cal_trig_q && reg_wdata[CAL_TRIG_BIT];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presc_cfg_q  <= CFG_RESET;
            sleep_cfg_q  <= CFG_RESET;
            reload_q     <= COUNT_ZERO;
            en_one_q     <= CFG_RESET;
            en_two_q     <= CFG_RESET;
            flag_reset_q <= 1'b0;
            cal_trig_q   <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_PRESCALER_CFG: presc_cfg_q <= reg_wdata;
                OFS_SLEEP_CLK_CFG: sleep_cfg_q <= reg_wdata;
                OFS_RELOAD_LOW:    reload_q[7:0] <= reg_wdata;
                OFS_RELOAD_HIGH:   reload_q[15:8] <= reg_wdata;
                OFS_LINE_ONE_EN:   en_one_q <= reg_wdata;
                OFS_LINE_TWO_EN:   en_two_q <= reg_wdata;
                OFS_TIMER_CTRL: begin
                    flag_reset_q <= reg_wdata[FLAG_RESET_BIT];
                    cal_trig_q   <= reg_wdata[CAL_TRIG_BIT];
                end
                default: ;
            endcase
        end
    end

    // Prescaler and down counter; held at the reload value while the clock is off.
    // Reload and prescaler writes restart the count, so they may follow source selection.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_q   <= COUNT_ZERO;
            count_q <= COUNT_ZERO;
        end else if (!clk_en) begin
            pre_q   <= COUNT_ZERO;
            count_q <= reload_q;
        end else if (reload_wr) begin
            pre_q   <= COUNT_ZERO;
            count_q <= reload_d;
        end else if (tick_sel) begin
            if (step) begin
                pre_q <= COUNT_ZERO;
                count_q <= (count_q == COUNT_ZERO) ? reload_q : count_q - COUNT_ONE;
            end else begin
                pre_q <= pre_q + COUNT_ONE;
            end
        end
    end

    // Sticky timeout flag; a new timeout wins over a clear in the same cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (hit) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cal_state_q <= SWT_CAL_IDLE;
            cal_cnt_q   <= '0;
            done_q      <= 1'b0;
        end else begin
            case (cal_state_q)
                SWT_CAL_IDLE: begin
                    if (cal_start) begin
                        cal_state_q <= SWT_CAL_RUN;
                        cal_cnt_q   <= 32'(CAL_CYCLES);
                        done_q      <= 1'b0;
                    end
                end
                SWT_CAL_RUN: begin
                    if (cal_cnt_q <= 32'd1) begin
                        cal_state_q <= SWT_CAL_IDLE;
                        cal_cnt_q   <= '0;
                        done_q      <= 1'b1;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 32'd1;
                    end
                end
                default: cal_state_q <= SWT_CAL_IDLE;
            endcase
        end
    end

    assign irq_line_one  = flag_q && en_one_q[WAKE_IRQ_BIT];
    assign irq_line_two  = flag_q && en_two_q[WAKE_IRQ_BIT];
    assign wake_req      = flag_q && sleep_cfg_q[ARM_BIT];
    assign rc_cal_active = (cal_state_q == SWT_CAL_RUN);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                OFS_PRESCALER_CFG: reg_rdata <= presc_cfg_q;
                OFS_SLEEP_CLK_CFG: reg_rdata <= sleep_cfg_q;
                OFS_RELOAD_LOW:    reg_rdata <= reload_q[7:0];
                OFS_RELOAD_HIGH:   reg_rdata <= reload_q[15:8];
                OFS_TIMER_CTRL:    reg_rdata <= {6'h00, cal_trig_q, flag_reset_q};
                OFS_OSC_STATE:     reg_rdata <= {5'h00, clk_en, flag_q, done_q};
                OFS_LINE_ONE_EN:   reg_rdata <= en_one_q;
                OFS_LINE_TWO_EN:   reg_rdata <= en_two_q;
                OFS_COUNT_LOW:     reg_rdata <= count_q[7:0];
                OFS_COUNT_HIGH:    reg_rdata <= count_q[15:8];
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_timeout;
        hit;
    endsequence

    sequence s_clear_write;
        flag_clr && !hit;
    endsequence

    no_tick_off_a: assert property (!clk_en |-> !step) else $error("step without clock source");
    presc_wrap_a: assert property (step |-> pre_q == div_m1) else $error("prescaler step early");
    count_dec_a: assert property (step && !reload_wr && count_q != COUNT_ZERO
        |=> count_q == $past(count_q) - COUNT_ONE)
        else $error("counter did not decrement");
    count_load_a: assert property (!clk_en |=> count_q == $past(reload_q)) else $error("reload not held");
    flag_set_a: assert property (s_timeout |=> flag_q) else $error("timeout flag not set");
    flag_hold_a: assert property (flag_q && !flag_clr |=> flag_q) else $error("flag dropped alone");
    flag_clear_a: assert property (s_clear_write |=> !flag_q) else $error("flag not cleared");
    irq_line_a: assert property (s_timeout ##0 en_two_q[WAKE_IRQ_BIT] && !(reg_wr && reg_addr == OFS_LINE_TWO_EN)
        |=> irq_line_two) else $error("line two irq missing");
    wake_arm_a: assert property (s_timeout ##0 sleep_cfg_q[ARM_BIT] && !(reg_wr && reg_addr == OFS_SLEEP_CLK_CFG)
        |=> wake_req) else $error("no wake");
    cal_begin_a: assert property (cal_start && !rc_cal_active |=> rc_cal_active && !done_q)
        else $error("calibration did not start");
    cal_end_a: assert property (rc_cal_active && cal_cnt_q == 32'd1 |=> done_q && !rc_cal_active)
        else $error("calibration done missing");
endmodule
`default_nettype wire

/* File: tb/swt_timer_tb.sv */
/*
 * Self-checking bench for the sleep wake-up timer: registers, prescaler, sources, timeout, calibration.
 * Assumes swt_pkg is compiled first; ticks are driven as single-cycle pulses two cycles apart.
 */
`timescale 1ns/10ps
`default_nettype none
module swt_timer_tb;
    import swt_pkg::*;
    localparam int CAL_N = 8;
    logic              clk_sys;
    logic              rst;
    logic              rc_tick;
    logic              xtal_tick;
    logic              reg_wr;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        reg_wdata;
    logic [7:0]        reg_rdata;
    logic              irq_line_one;
    logic              irq_line_two;
    logic              wake_req;
    logic              rc_cal_active;
    int                errors;
    int                n_tests;
    int                cycles;
    int                n;
    logic [7:0]        b;
    logic [15:0]       c;
    logic [15:0]       r;

    swt_timer #(.CAL_CYCLES(CAL_N)) dut (.clk_sys(clk_sys), .rst(rst), .rc_tick(rc_tick), .xtal_tick(xtal_tick),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .irq_line_one(irq_line_one), .irq_line_two(irq_line_two), .wake_req(wake_req), .rc_cal_active(rc_cal_active));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys) #1;
        reg_wr = 1'b0;
        @(posedge clk_sys) #1;
    endtask

    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        reg_addr = a;
        @(posedge clk_sys) #1;
        d = reg_rdata;
    endtask

    task automatic rd_cnt(output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(OFS_COUNT_LOW, lo);
        rd(OFS_COUNT_HIGH, hi);
        v = {hi, lo};
    endtask

    task automatic ticks(input int k, input bit xt);
        repeat (k) begin
            if (xt) xtal_tick = 1'b1;
            else rc_tick = 1'b1;
            @(posedge clk_sys) #1;
            rc_tick = 1'b0;
            xtal_tick = 1'b0;
            @(posedge clk_sys) #1;
        end
    endtask

    // Source is selected first; reload and prescaler writes then restart the count.
    task automatic setup(input logic [3:0] src, input logic [2:0] pc, input logic [15:0] rl, input bit arm);
        wr(OFS_SLEEP_CLK_CFG, {1'b0, src, 3'h0});
        wr(OFS_RELOAD_LOW, rl[7:0]);
        wr(OFS_RELOAD_HIGH, rl[15:8]);
        wr(OFS_PRESCALER_CFG, {5'h00, pc});
        wr(OFS_TIMER_CTRL, 8'h01);
        wr(OFS_TIMER_CTRL, 8'h00);
        wr(OFS_SLEEP_CLK_CFG, {arm, src, 3'h0});
    endtask

    function automatic int div_of(input int code);
        int t[8] = '{1, 4, 8, 16, 128, 1024, 8192, 65536};
        return t[code];
    endfunction

    initial begin
        {rc_tick, xtal_tick, reg_wr, reg_wdata} = '0;
        reg_addr = '0;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        rst = 1'b1;
        void'($urandom(32'h1874_fb55));
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        rd(OFS_PRESCALER_CFG, b);
        check(16'(b), 16'h0000);
        rd(OFS_SLEEP_CLK_CFG, b);
        check(16'(b), 16'h0000);
        rd(OFS_OSC_STATE, b);
        check(16'({b, irq_line_one, irq_line_two, wake_req, rc_cal_active}), 16'h0000);
        $display("test reset done");
        for (int k = 0; k < 7; k++) begin
            setup(SRC_RC, 3'(k), 16'h0010, 1'b0);
            ticks(div_of(k) - 1, 1'b0);
            rd_cnt(c);
            check(c, 16'h0010);
            ticks(1, 1'b0);
            rd_cnt(c);
            check(c, 16'h000F);
        end
        setup(SRC_RC, 3'h7, 16'h0010, 1'b0);
        ticks(300, 1'b0);
        rd_cnt(c);
        check(c, 16'h0010);
        $display("test prescaler done");
        setup(SRC_XTAL, 3'h0, 16'h0020, 1'b0);
        ticks(3, 1'b0);
        rd_cnt(c);
        check(c, 16'h0020);
        ticks(3, 1'b1);
        rd_cnt(c);
        check(c, 16'h001D);
        setup(4'h5, 3'h0, 16'h0020, 1'b0);
        ticks(2, 1'b0);
        ticks(2, 1'b1);
        rd_cnt(c);
        check(c, 16'h0020);
        $display("test source done");
        wr(OFS_LINE_ONE_EN, 8'h01);
        wr(OFS_LINE_TWO_EN, 8'h00);
        setup(SRC_RC, 3'h0, 16'h0002, 1'b1);
        ticks(1, 1'b0);
        check(16'({irq_line_one, irq_line_two, wake_req}), 16'h0000);
        ticks(1, 1'b0);
        check(16'({irq_line_one, irq_line_two, wake_req}), 16'h0005);
        ticks(1, 1'b0);
        rd_cnt(c);
        check(c, 16'h0002);
        rd(OFS_OSC_STATE, b);
        check(16'(b[FLAG_BIT]), 16'h0001);
        wr(OFS_LINE_TWO_EN, 8'h01);
        wr(OFS_TIMER_CTRL, 8'h01);
        check(16'({irq_line_one, irq_line_two, wake_req}), 16'h0007);
        wr(OFS_TIMER_CTRL, 8'h00);
        @(posedge clk_sys) #1;
        check(16'({irq_line_one, irq_line_two, wake_req}), 16'h0000);
        $display("test timeout done");
        wr(OFS_TIMER_CTRL, 8'h00);
        wr(OFS_TIMER_CTRL, 8'h02);
        @(posedge clk_sys) #1;
        check(16'(rc_cal_active), 16'h0001);
        repeat (CAL_N - 3) @(posedge clk_sys);
        #1 check(16'(rc_cal_active), 16'h0001);
        @(posedge clk_sys) #1;
        check(16'(rc_cal_active), 16'h0000);
        repeat (3) @(posedge clk_sys);
        rd(OFS_OSC_STATE, b);
        check(16'({rc_cal_active, b[CAL_DONE_BIT]}), 16'h0001);
        wr(OFS_TIMER_CTRL, 8'h02);
        repeat (2) @(posedge clk_sys);
        #1 check(16'(rc_cal_active), 16'h0000);
        $display("test calibration done");
        wr(11'h300, 8'hFF);
        rd(11'h300, b);
        check(16'(b), 16'h0000);
        rd(OFS_PRESCALER_CFG, b);
        check(16'(b), 16'h0000);
        $display("test unmapped done");
        repeat (20) begin
            r = 16'($urandom_range(32'h0000_FFFF, 32'h0000_0100));
            n = $urandom_range(60, 1);
            setup(SRC_RC, 3'h0, r, 1'b0);
            ticks(n, 1'b0);
            rd_cnt(c);
            check(c, r - 16'(n));
        end
        $display("test random done");
        end_of_test();
    end
endmodule
`default_nettype wire
